//--- rtl/clock_ctrl_pkg.sv
// Constants shared by the main clock controller and its leaves
// Notes on behaviour
// - Main source clock feeds one 8-bit prescaler; all CPU and bus clocks derive from it.
// - After reset the CPU domain runs from the main clock undivided.
// - Controller is always on; no enable bit and no soft reset of its own.
// - CPU domain rate equals main clock rate divided by the divider register; a code written while ready reads zero is stored but not applied.
// - Forbidden divider codes are stored but not used; a violation is signalled.
// - Divider writes accepted while running; new ratio hits all domain clocks together.
// - Ready flag reads zero between a divider write and the new ratio taking effect.
// - Enabled ready interrupt fires when the new ratio takes effect.
// - Rewriting settings while ready reads zero is reported as a violation.
// - Each mask bit gates one module clock; one supplies it, zero stops it.
// - Mask registers reset with system modules on, optional peripherals off.
// - A module with its bus clock masked cannot be accessed until unmasked.
// - Modules on several domains own one independent mask bit per domain.
// - Masking own bus or bridge clock locks the mask registers until reset.
// - Ready interrupt doubles as a synchronous wakeup toward power management.
// - Enable-set and enable-clear take ones only and read back one enable.
// - Interrupt request is high while flag and enable are both set.
// - Writing one to the ready flag clears it; zero leaves it.
// - Runs in idle; in standby freezes unless a synchronous clock is needed.
// - Byte, halfword and word accesses, with byte lanes, are supported.
// - Protectable registers ignore writes while the access controller protects them.
// - Control register holds only reserved bits, reading zero.
// - Divider takes one-hot codes 1 to 128 only; reset value divides by one.
// - Ready flag sets when the clocks reach their setting; set after reset.
package clock_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CONTROL_A    = 10'h000;
  localparam logic [9:0]  IDX_IRQ_EN_CLR   = 10'h001;
  localparam logic [9:0]  IDX_IRQ_EN_SET   = 10'h002;
  localparam logic [9:0]  IDX_IRQ_FLAG     = 10'h003;
  localparam logic [9:0]  IDX_CPU_DIV      = 10'h005;
  localparam logic [9:0]  IDX_FAST_MASK    = 10'h010;
  localparam logic [9:0]  IDX_BRIDGE_A     = 10'h014;
  localparam logic [9:0]  IDX_BRIDGE_B     = 10'h018;
  localparam logic [9:0]  IDX_BRIDGE_C     = 10'h01C;

  // Field positions
  localparam int          READY_BIT        = 0;
  localparam int          FAST_BRIDGE_A    = 0;
  localparam int          BRIDGE_A_OWN     = 2;

  // Reset values
  localparam logic [7:0]  CPU_DIV_RESET    = 8'h01;
  localparam logic [31:0] FAST_MASK_RESET  = 32'h00001CFF;
  localparam logic [31:0] BRIDGE_A_RESET   = 32'h00000FFF;
  localparam logic [31:0] BRIDGE_B_RESET   = 32'h00000007;
  localparam logic [31:0] BRIDGE_C_RESET   = 32'h00000000;

  // Writable bits of each mask register
  localparam logic [31:0] FAST_MASK_WR     = 32'h000017FF;
  localparam logic [31:0] BRIDGE_A_WR      = 32'h00001FFF;
  localparam logic [31:0] BRIDGE_B_WR      = 32'h00000027;
  localparam logic [31:0] BRIDGE_C_WR      = 32'h00DFFE7F;

  // Prescaler geometry
  localparam int          PRESCALE_WIDTH   = 8;
  localparam int          RATIO_BITS       = 3;
  localparam int          COUNT_BITS       = 7;

endpackage

//--- rtl/mask_register.sv
// One clock mask register with byte lanes and read-only bits
`timescale 1ns/1ps
`default_nettype none
module mask_register #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITABLE    = 32'hFFFFFFFF
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wstrb,
  input  wire logic [31:0] wdata,
  output logic [31:0]      value_q
);

  // Each lane updates on its own strobe
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          value_q[lane*8 +: 8] <= RESET_VALUE[lane*8 +: 8];
        end else if (wr_en && wstrb[lane]) begin
          value_q[lane*8 +: 8] <= (wdata[lane*8 +: 8] & WRITABLE[lane*8 +: 8]) |
                                  (value_q[lane*8 +: 8] & ~WRITABLE[lane*8 +: 8]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- rtl/clock_prescaler.sv
// Glitch-free power-of-two prescaler producing the CPU clock enable
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler
  import clock_ctrl_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  load,
  input  wire logic [RATIO_BITS-1:0] ratio_log2,
  input  wire logic                  freeze,
  output logic                       tick_q,
  output logic                       settled_q
);

  logic [COUNT_BITS-1:0] count_q;
  logic [RATIO_BITS-1:0] cur_q;
  logic [RATIO_BITS-1:0] pend_q;
  logic                  pending_q;
  logic                  boundary;

  // Low-bit mask of the count for a ratio
  function automatic logic [COUNT_BITS-1:0] ratio_mask(input logic [RATIO_BITS-1:0] r);
    ratio_mask = COUNT_BITS'((8'h01 << r) - 8'h01);
  endfunction

  // Count wraps at a point common to every ratio
  assign boundary = (count_q == {COUNT_BITS{1'b1}});

  // Free-running divider count, held in frozen standby
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (!freeze) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Pending ratio waits for the common boundary
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_q     <= '0;
      pend_q    <= '0;
      pending_q <= 1'b0;
      settled_q <= 1'b0;
    end else begin
      settled_q <= 1'b0;
      if (load) begin
        pend_q    <= ratio_log2;
        pending_q <= 1'b1;
      end else if (pending_q && boundary && !freeze) begin
        cur_q     <= pend_q;
        pending_q <= 1'b0;
        settled_q <= 1'b1;
      end
    end
  end

  // One enable per ratio period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !freeze && ((count_q & ratio_mask(cur_q)) == ratio_mask(cur_q));
    end
  end

endmodule
`default_nettype wire

//--- rtl/main_clock_prescaler_gating.sv
// Main clock controller: prescaler, ready flag, interrupt and clock masks
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module main_clock_prescaler_gating
  import clock_ctrl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Access controller
  input  wire logic        write_protect,
  output logic             access_violation,
  // Power management
  input  wire logic        standby_mode,
  input  wire logic        sync_clock_needed,
  output logic             wakeup_request,
  // Interrupt
  output logic             clock_ready_irq,
  // Clock enables and gates
  output logic             cpu_clock_en,
  output logic [31:0]      fast_bus_clock_mask,
  output logic [31:0]      bridge_a_clock_mask,
  output logic [31:0]      bridge_b_clock_mask,
  output logic [31:0]      bridge_c_clock_mask
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      violation_q;
  logic                      irq_q;
  logic                      wake_q;
  logic                      irq_enable_q;
  logic                      ready_flag_q;
  logic [PRESCALE_WIDTH-1:0] cpu_div_q;
  logic [31:0]               fast_mask_q;
  logic [31:0]               bridge_a_q;
  logic [31:0]               bridge_b_q;
  logic [31:0]               bridge_c_q;
  logic                      tick;
  logic                      settled;
  logic                      freeze;
  logic                      access;
  logic                      commit;
  logic                      wr_commit;
  logic                      mapped;
  logic                      masks_locked;
  logic                      wr_allowed;
  logic                      lane0;
  logic                      div_write;
  logic                      div_legal;
  logic                      div_apply;
  logic [31:0]               read_word;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Word decode of the APB address against a register index
  function automatic logic hits(input logic [11:0] addr, input logic [9:0] idx);
    hits = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  // Only single-bit codes are legal division factors
  function automatic logic one_hot(input logic [PRESCALE_WIDTH-1:0] v);
    one_hot = (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction

  // Bit position of a one-hot code
  function automatic logic [RATIO_BITS-1:0] log2_of(input logic [PRESCALE_WIDTH-1:0] v);
    log2_of = '0;
    for (int i = 0; i < PRESCALE_WIDTH; i++) begin
      if (v[i]) begin
        log2_of = RATIO_BITS'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus access qualification
  // ----------------------------------------------------------------

  // First access cycle and the completing edge
  assign access    = psel && penable && !pready_q;
  assign commit    = psel && penable && pready_q;
  assign wr_commit = commit && pwrite && !pslverr_q;
  assign lane0     = pstrb[0];

  // Any word of the map
  assign mapped = hits(paddr, IDX_CONTROL_A)  || hits(paddr, IDX_IRQ_EN_CLR) ||
                  hits(paddr, IDX_IRQ_EN_SET) || hits(paddr, IDX_IRQ_FLAG)   ||
                  hits(paddr, IDX_CPU_DIV)    || hits(paddr, IDX_FAST_MASK)  ||
                  hits(paddr, IDX_BRIDGE_A)   || hits(paddr, IDX_BRIDGE_B)   ||
                  hits(paddr, IDX_BRIDGE_C);

  // Protection covers all writable registers except the flag
  assign wr_allowed = !write_protect || hits(paddr, IDX_IRQ_FLAG);

  // Own bus clock or bridge clock off leaves masks frozen until reset
  assign masks_locked = !bridge_a_q[BRIDGE_A_OWN] || !fast_mask_q[FAST_BRIDGE_A];

  // ----------------------------------------------------------------
  // Divider write handling
  // ----------------------------------------------------------------

  // Divider write that reaches the register
  assign div_write = wr_commit && wr_allowed && lane0 && hits(paddr, IDX_CPU_DIV);
  assign div_legal = one_hot(pwdata[PRESCALE_WIDTH-1:0]);

  // Only a legal code written while settled reaches the prescaler
  assign div_apply = div_write && div_legal && ready_flag_q;

  // Divider register keeps whatever software wrote
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_div_q <= CPU_DIV_RESET;
    end else if (div_write) begin
      cpu_div_q <= pwdata[PRESCALE_WIDTH-1:0];
    end
  end

  // Standby freeze when no synchronous clock is needed
  assign freeze = standby_mode && !sync_clock_needed;

  // Shared prescaler for the CPU and bus domain
  clock_prescaler u_prescaler (
    .clock      (clock),
    .rst        (rst),
    .load       (div_apply),
    .ratio_log2 (log2_of(pwdata[PRESCALE_WIDTH-1:0])),
    .freeze     (freeze),
    .tick_q     (tick),
    .settled_q  (settled)
  );

  // ----------------------------------------------------------------
  // Clock ready flag and interrupt
  // ----------------------------------------------------------------

  // Flag drops on an applied write and rises once the ratio settles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_flag_q <= 1'b1;
    end else if (settled) begin
      ready_flag_q <= 1'b1;
    end else if (div_apply) begin
      ready_flag_q <= 1'b0;
    end else if (wr_commit && lane0 && hits(paddr, IDX_IRQ_FLAG) && pwdata[READY_BIT]) begin
      ready_flag_q <= 1'b0;
    end
  end

  // Enable bit shared by the set and clear views
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_enable_q <= 1'b0;
    end else if (wr_commit && wr_allowed && lane0 && pwdata[READY_BIT]) begin
      if (hits(paddr, IDX_IRQ_EN_SET)) begin
        irq_enable_q <= 1'b1;
      end else if (hits(paddr, IDX_IRQ_EN_CLR)) begin
        irq_enable_q <= 1'b0;
      end
    end
  end

  // Request level follows flag and enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= ready_flag_q && irq_enable_q;
      wake_q <= ready_flag_q && irq_enable_q;
    end
  end

  // Violation pulse toward the access controller
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      violation_q <= 1'b0;
    end else begin
      violation_q <= div_write && (!div_legal || !ready_flag_q);
    end
  end

  // ----------------------------------------------------------------
  // Clock mask registers
  // ----------------------------------------------------------------

  // Fast bus clock gates; bridges, DMA, debug and flash on at reset
  mask_register #(
    .RESET_VALUE (FAST_MASK_RESET),
    .WRITABLE    (FAST_MASK_WR)
  ) u_fast_mask (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (wr_commit && wr_allowed && !masks_locked && hits(paddr, IDX_FAST_MASK)),
    .wstrb   (pstrb),
    .wdata   (pwdata),
    .value_q (fast_mask_q)
  );

  // Bridge A gates for system modules, all but sensor on at reset
  mask_register #(
    .RESET_VALUE (BRIDGE_A_RESET),
    .WRITABLE    (BRIDGE_A_WR)
  ) u_bridge_a (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (wr_commit && wr_allowed && !masks_locked && hits(paddr, IDX_BRIDGE_A)),
    .wstrb   (pstrb),
    .wdata   (pwdata),
    .value_q (bridge_a_q)
  );

  // Bridge B gates; port, debug and flash on at reset
  mask_register #(
    .RESET_VALUE (BRIDGE_B_RESET),
    .WRITABLE    (BRIDGE_B_WR)
  ) u_bridge_b (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (wr_commit && wr_allowed && !masks_locked && hits(paddr, IDX_BRIDGE_B)),
    .wstrb   (pstrb),
    .wdata   (pwdata),
    .value_q (bridge_b_q)
  );

  // Bridge C gates; analog, timer, serial, event and touch off at reset
  mask_register #(
    .RESET_VALUE (BRIDGE_C_RESET),
    .WRITABLE    (BRIDGE_C_WR)
  ) u_bridge_c (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (wr_commit && wr_allowed && !masks_locked && hits(paddr, IDX_BRIDGE_C)),
    .wstrb   (pstrb),
    .wdata   (pwdata),
    .value_q (bridge_c_q)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Register selection; control word is all reserved
  always_comb begin
    read_word = 32'h00000000;
    if (hits(paddr, IDX_CONTROL_A)) begin
      read_word = 32'h00000000;
    end else if (hits(paddr, IDX_IRQ_EN_CLR) || hits(paddr, IDX_IRQ_EN_SET)) begin
      read_word[READY_BIT] = irq_enable_q;
    end else if (hits(paddr, IDX_IRQ_FLAG)) begin
      read_word[READY_BIT] = ready_flag_q;
    end else if (hits(paddr, IDX_CPU_DIV)) begin
      read_word[PRESCALE_WIDTH-1:0] = cpu_div_q;
    end else if (hits(paddr, IDX_FAST_MASK)) begin
      read_word = fast_mask_q;
    end else if (hits(paddr, IDX_BRIDGE_A)) begin
      read_word = bridge_a_q;
    end else if (hits(paddr, IDX_BRIDGE_B)) begin
      read_word = bridge_b_q;
    end else if (hits(paddr, IDX_BRIDGE_C)) begin
      read_word = bridge_c_q;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------

  // One wait state: ready, data and error registered together on the same edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (access) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped; // Unmapped word answers with error
      prdata_q  <= pwrite ? 32'h00000000 : read_word;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Straight from flip-flops
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign access_violation    = violation_q;
  assign clock_ready_irq     = irq_q;
  assign wakeup_request      = wake_q;
  assign cpu_clock_en        = tick;

  // Mask bits are the module clock gates and bus access enables
  assign fast_bus_clock_mask = fast_mask_q;
  assign bridge_a_clock_mask = bridge_a_q;
  assign bridge_b_clock_mask = bridge_b_q;
  assign bridge_c_clock_mask = bridge_c_q;

  // No enable or soft reset exists; only the system reset acts
  // on this block, so it runs from power-up onward.

endmodule
`default_nettype wire

//--- dv/cpu_clock_sink.sv
// Model of the CPU side: times and counts the CPU clock enable pulses
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_sink (
  input  wire logic   clock,
  input  wire logic   rst,
  input  wire logic   cpu_clock_en,
  output logic [7:0]  period_q,
  output logic [15:0] ticks_q
);
  logic [7:0] gap_q;
  // Cycles between enable pulses and number of pulses taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q    <= 8'h01;
      period_q <= 8'h00;
      ticks_q  <= 16'h0000;
    end else if (cpu_clock_en) begin
      gap_q    <= 8'h01;
      period_q <= gap_q;
      ticks_q  <= ticks_q + 16'h0001;
    end else begin
      gap_q    <= gap_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- dv/clock_ctrl_monitor.sv
// Concurrent checks on the main clock controller ports
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_monitor
  import clock_ctrl_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        write_protect,
  input wire logic        access_violation,
  input wire logic        standby_mode,
  input wire logic        sync_clock_needed,
  input wire logic        wakeup_request,
  input wire logic        clock_ready_irq,
  input wire logic        cpu_clock_en,
  input wire logic [31:0] fast_bus_clock_mask,
  input wire logic [31:0] bridge_a_clock_mask,
  input wire logic [31:0] bridge_b_clock_mask,
  input wire logic [31:0] bridge_c_clock_mask
);
  logic       frozen;
  logic       frz_q;
  logic [8:0] gap_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Freeze request as the prescaler sees it
  assign frozen = standby_mode & ~sync_clock_needed;
  // Gap between pulses, marked when a freeze fell inside it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= 9'h001;
      frz_q <= 1'b0;
    end else begin
      gap_q <= cpu_clock_en ? 9'h001 : gap_q + {8'h00, gap_q != 9'h1FF};
      frz_q <= cpu_clock_en ? frozen : (frz_q | frozen);
    end
  end
  access_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing one cycle into access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  wake_irq_a: assert property (wakeup_request == clock_ready_irq)
    else $error("wakeup differs from interrupt");
  viol_cause_a: assert property (access_violation |-> $past(pready && pwrite))
    else $error("violation without a committed write");
  div_gap_a: assert property (cpu_clock_en && !frz_q |->
    gap_q <= 9'h080 && (gap_q & (gap_q - 9'h001)) == 9'h000)
    else $error("enable gap not a power of two");
  freeze_hold_a: assert property (frozen [*3] |-> !cpu_clock_en)
    else $error("enable pulse while frozen");
  lock_hold_a: assert property (!bridge_a_clock_mask[BRIDGE_A_OWN] ||
    !fast_bus_clock_mask[FAST_BRIDGE_A] |=> $stable(fast_bus_clock_mask)
    && $stable(bridge_a_clock_mask) && $stable(bridge_b_clock_mask))
    else $error("mask changed while locked");
  ro_bits_a: assert property (fast_bus_clock_mask[11] &&
    !bridge_c_clock_mask[21] && bridge_c_clock_mask[8:7] == 2'h0)
    else $error("read-only mask bit changed");
  protect_hold_a: assert property (pready && pwrite && write_protect |=>
    $stable(bridge_b_clock_mask) && $stable(bridge_c_clock_mask))
    else $error("protected write changed a mask");
  cover property (access_violation);
  cover property ($rose(clock_ready_irq));
  cover property (!fast_bus_clock_mask[FAST_BRIDGE_A]);
endmodule
bind main_clock_prescaler_gating clock_ctrl_monitor u_mon (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .write_protect(write_protect), .access_violation(access_violation),
  .standby_mode(standby_mode), .sync_clock_needed(sync_clock_needed),
  .wakeup_request(wakeup_request), .clock_ready_irq(clock_ready_irq),
  .cpu_clock_en(cpu_clock_en), .fast_bus_clock_mask(fast_bus_clock_mask),
  .bridge_a_clock_mask(bridge_a_clock_mask),
  .bridge_b_clock_mask(bridge_b_clock_mask),
  .bridge_c_clock_mask(bridge_c_clock_mask));
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the main clock controller
`timescale 1ns/1ps
`default_nettype none
module tb
  import clock_ctrl_pkg::*;
;
  logic        clock, rst, psel, penable, pwrite, err_q;
  logic        pready, pslverr, write_protect, access_violation;
  logic        standby_mode, sync_clock_needed, wakeup_request;
  logic        clock_ready_irq, cpu_clock_en;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd_q, fm, bam, bbm, bcm;
  logic [7:0]  period;
  logic [15:0] ticks, t0;
  int          n_mismatch, checks_done, viol_n = 0, v0;
  main_clock_prescaler_gating uut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_protect(write_protect), .access_violation(access_violation),
    .standby_mode(standby_mode), .sync_clock_needed(sync_clock_needed),
    .wakeup_request(wakeup_request), .clock_ready_irq(clock_ready_irq),
    .cpu_clock_en(cpu_clock_en), .fast_bus_clock_mask(fm),
    .bridge_a_clock_mask(bam), .bridge_b_clock_mask(bbm),
    .bridge_c_clock_mask(bcm));
  cpu_clock_sink u_cpu (.clock(clock), .rst(rst), .cpu_clock_en(cpu_clock_en),
    .period_q(period), .ticks_q(ticks));
  // Clock and violation pulse counter
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (access_violation === 1'b1) viol_n <= viol_n + 1;
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, i, d, 4'hF);
  endtask
  task automatic rc(input string nm, input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0, 4'hF);
    chk(nm, rd_q, e);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    rd_q = 32'h0;
    while (rd_q[READY_BIT] !== 1'b1) begin
      apb(1'b0, IDX_IRQ_FLAG, 32'h0, 4'hF);
      n++;
      if (n > 100) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_reset;
    rc("control", IDX_CONTROL_A, 32'h0);
    wr(IDX_CONTROL_A, 32'hFF);
    rc("control_wr", IDX_CONTROL_A, 32'h0);
    rc("flag", IDX_IRQ_FLAG, 32'h1);
    rc("enable", IDX_IRQ_EN_SET, 32'h0);
    rc("divider", IDX_CPU_DIV, {24'h0, CPU_DIV_RESET});
    rc("fast", IDX_FAST_MASK, FAST_MASK_RESET);
    rc("bridge_a", IDX_BRIDGE_A, BRIDGE_A_RESET);
    rc("bridge_b", IDX_BRIDGE_B, BRIDGE_B_RESET);
    rc("bridge_c", IDX_BRIDGE_C, BRIDGE_C_RESET);
    chk("bridge_a_out", bam, BRIDGE_A_RESET);
    chk("period", {24'h0, period}, 32'h1);
    apb(1'b0, 10'h004, 32'h0, 4'hF);
    chk("unmapped", 32'(err_q), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_div;
    wr(IDX_IRQ_EN_SET, 32'h1);
    rc("en_clr_rd", IDX_IRQ_EN_CLR, 32'h1);
    standby_mode <= 1'b1;
    wr(IDX_CPU_DIV, 32'h4);
    rc("flag_busy", IDX_IRQ_FLAG, 32'h0);
    v0 = viol_n;
    wr(IDX_CPU_DIV, 32'h8);
    repeat (2) @(posedge clock);
    chk("viol_busy", viol_n, v0 + 1);
    rc("div_stored", IDX_CPU_DIV, 32'h8);
    t0 = ticks;
    repeat (40) @(posedge clock);
    chk("frozen", 32'(ticks - t0), 32'h0);
    standby_mode <= 1'b0;
    wait_ready();
    repeat (20) @(posedge clock);
    chk("period_4", {24'h0, period}, 32'h4);
    chk("irq", 32'(clock_ready_irq), 32'h1);
    chk("wakeup", 32'(wakeup_request), 32'h1);
    wr(IDX_IRQ_FLAG, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq_clr", 32'(clock_ready_irq), 32'h0);
    rc("flag_clr", IDX_IRQ_FLAG, 32'h0);
    wr(IDX_IRQ_EN_CLR, 32'h1);
    rc("en_set_rd", IDX_IRQ_EN_SET, 32'h0);
    $display("test divider done");
  endtask
  task automatic t_bad;
    v0 = viol_n;
    wr(IDX_CPU_DIV, 32'h3);
    repeat (2) @(posedge clock);
    chk("viol_code", viol_n, v0 + 1);
    rc("div_bad", IDX_CPU_DIV, 32'h3);
    standby_mode      <= 1'b1;
    sync_clock_needed <= 1'b1;
    repeat (2) @(posedge clock);
    t0 = ticks;
    repeat (40) @(posedge clock);
    chk("needed_run", 32'(ticks - t0), 32'hA);
    standby_mode      <= 1'b0;
    $display("test bad code done");
  endtask
  task automatic t_mask;
    wr(IDX_BRIDGE_C, 32'hFFFFFFFF);
    rc("bc_all", IDX_BRIDGE_C, BRIDGE_C_WR);
    chk("bc_out", bcm, BRIDGE_C_WR);
    apb(1'b1, IDX_BRIDGE_C, 32'h0, 4'h2);
    rc("bc_lane", IDX_BRIDGE_C, BRIDGE_C_WR & 32'hFFFF00FF);
    write_protect <= 1'b1;
    wr(IDX_BRIDGE_B, 32'h0);
    rc("bb_prot", IDX_BRIDGE_B, BRIDGE_B_RESET);
    write_protect <= 1'b0;
    wr(IDX_BRIDGE_B, 32'h20);
    rc("bb_own", IDX_BRIDGE_B, 32'h20);
    chk("fast_kept", fm, FAST_MASK_RESET);
    wr(IDX_FAST_MASK, 32'h0);
    rc("fast_ro", IDX_FAST_MASK, 32'h800);
    wr(IDX_BRIDGE_B, 32'h7);
    rc("bb_lock", IDX_BRIDGE_B, 32'h20);
    do_reset();
    rc("fast_rst", IDX_FAST_MASK, FAST_MASK_RESET);
    $display("test masks done");
  endtask
  // Main sequence
  initial begin
    rst               = 1'b1;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 12'h000;
    pwdata            = 32'h0;
    pstrb             = 4'h0;
    write_protect     = 1'b0;
    standby_mode      = 1'b0;
    sync_clock_needed = 1'b0;
    n_mismatch        = 0;
    checks_done       = 0;
    do_reset();
    t_reset();
    t_div();
    t_bad();
    t_mask();
    end_of_test();
  end
  // Overall run limit
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
